/* src/dpio_ports.sv */
// Two parallel I/O ports (8-bit and 6-bit) behind an AXI4-Lite slave.
// Assumes pins arrive asynchronously and a single 125 MHz clock.
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ns
`include "dpio_regs.svh"

module dpio_ports (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_clk_en,
    input wire logic i_pulldown_reset_default_option,
    input wire logic i_port_interrupt_option,
    input wire logic [7:0] i_first_port_bits,
    input wire logic [5:0] i_second_port_bits,
    output logic [7:0] o_first_port_bits,
    output logic [7:0] o_first_port_bits_oe,
    output logic [7:0] o_first_port_pull_disable_bits,
    output logic [5:0] o_second_port_bits,
    output logic [5:0] o_second_port_bits_oe,
    output logic [5:0] o_second_port_pull_disable_bits,
    output logic [3:0] o_ext_irq_pins,
    input wire logic [9:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [9:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import dpio_pkg::*;

    logic [7:0] a_latch_q, a_dir_q, a_pdi_q;
    logic [5:0] b_latch_q, b_dir_q, b_pdi_q;
    logic [7:0] a_pin_s;
    logic [5:0] b_pin_s;
    logic [9:0] awaddr_q;
    logic aw_held_q, w_held_q;
    logic [31:0] wdata_q;
    logic wstrb0_q;
    dpio_wr_state_type wr_state_q;
    dpio_rresp_type rd_d;
    logic rst_seen_q;
    // Port B latch written at least once since power-up
    logic b_loaded_q = 1'b0;

    // Pin levels pass two flops before any read logic
    dpio_sync #(.WIDTH(8)) u_sync_a (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_enable(i_clk_en),
        .i_async(i_first_port_bits),
        .o_sync(a_pin_s)
    );
    dpio_sync #(.WIDTH(6)) u_sync_b (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_enable(i_clk_en),
        .i_async(i_second_port_bits),
        .o_sync(b_pin_s)
    );

    // Write decode
    // Only handshaked items count, so nothing is taken while ready is low
    wire aw_have = aw_held_q | (s_axi_awvalid & s_axi_awready);
    wire w_have = w_held_q | (s_axi_wvalid & s_axi_wready);
    wire [9:0] aw_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
    wire [31:0] w_data = w_held_q ? wdata_q : s_axi_wdata;
    wire w_lane0 = w_held_q ? wstrb0_q : s_axi_wstrb[0];
    wire wr_fire = i_clk_en && !i_rst && (wr_state_q == DPIO_WR_IDLE)
        && aw_have && w_have;
    wire [7:0] wr_idx = aw_addr[9:2];
    wire wr_aligned = (aw_addr[1:0] == 2'b00);
    wire wr_hit_a_l = wr_aligned && (wr_idx == `DPIO_IDX_A_LATCH);
    wire wr_hit_b_l = wr_aligned && (wr_idx == `DPIO_IDX_B_LATCH);
    wire wr_hit_a_d = wr_aligned && (wr_idx == `DPIO_IDX_A_DIR);
    wire wr_hit_b_d = wr_aligned && (wr_idx == `DPIO_IDX_B_DIR);
    wire wr_hit_a_p = wr_aligned && (wr_idx == `DPIO_IDX_A_PDI);
    wire wr_hit_b_p = wr_aligned && (wr_idx == `DPIO_IDX_B_PDI);
    wire wr_mapped = wr_hit_a_l | wr_hit_b_l | wr_hit_a_d | wr_hit_b_d
        | wr_hit_a_p | wr_hit_b_p;
    wire wr_en = wr_fire && w_lane0;

    // Read decode
    wire [7:0] rd_idx = s_axi_araddr[9:2];
    wire rd_aligned = (s_axi_araddr[1:0] == 2'b00);
    wire rd_fire = i_clk_en && s_axi_arvalid && !s_axi_rvalid;
    // Output bits read the latch; inputs read the pin
    wire [7:0] a_view = (a_dir_q & a_latch_q) | (~a_dir_q & a_pin_s);
    wire [5:0] b_view = (b_dir_q & b_latch_q) | (~b_dir_q & b_pin_s);

    always_comb begin
        rd_d.data = 32'h0000_0000;
        rd_d.resp = `DPIO_RESP_OKAY;
        if (!rd_aligned) begin
            rd_d.resp = `DPIO_RESP_SLVERR;
        end else begin
            case (rd_idx)
                `DPIO_IDX_A_LATCH: rd_d.data[7:0] = a_view;
                // Upper port B bits read zero
                `DPIO_IDX_B_LATCH: rd_d.data[5:0] = b_view;
                `DPIO_IDX_A_DIR: rd_d.data[7:0] = a_dir_q;
                `DPIO_IDX_B_DIR: rd_d.data[5:0] = b_dir_q;
                `DPIO_IDX_A_PDI: rd_d.data = 32'h0000_0000;
                `DPIO_IDX_B_PDI: rd_d.data = 32'h0000_0000;
                default: rd_d.resp = `DPIO_RESP_SLVERR;
            endcase
        end
    end

    // AXI write channel holding and response
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb0_q <= 1'b0;
            wr_state_q <= DPIO_WR_IDLE;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `DPIO_RESP_OKAY;
        end else if (i_clk_en) begin
            case (wr_state_q)
                DPIO_WR_IDLE: begin
                    if (wr_fire) begin
                        aw_held_q <= 1'b0;
                        w_held_q <= 1'b0;
                        s_axi_bvalid <= 1'b1;
                        s_axi_bresp <= wr_mapped ? `DPIO_RESP_OKAY
                            : `DPIO_RESP_SLVERR;
                        wr_state_q <= DPIO_WR_RESP;
                    end else begin
                        if (s_axi_awvalid && s_axi_awready) begin
                            aw_held_q <= 1'b1;
                            awaddr_q <= s_axi_awaddr;
                        end
                        if (s_axi_wvalid && s_axi_wready) begin
                            w_held_q <= 1'b1;
                            wdata_q <= s_axi_wdata;
                            wstrb0_q <= s_axi_wstrb[0];
                        end
                    end
                end
                DPIO_WR_RESP: begin
                    if (s_axi_bready) begin
                        s_axi_bvalid <= 1'b0;
                        wr_state_q <= DPIO_WR_IDLE;
                    end
                end
                default: wr_state_q <= DPIO_WR_IDLE;
            endcase
        end
    end

    // Channel readies are registered; high while idle and not yet held
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else if (i_clk_en) begin
            s_axi_awready <= (wr_state_q == DPIO_WR_RESP && s_axi_bready)
                || (wr_state_q == DPIO_WR_IDLE && !wr_fire
                && !(aw_held_q || s_axi_awvalid && s_axi_awready));
            s_axi_wready <= (wr_state_q == DPIO_WR_RESP && s_axi_bready)
                || (wr_state_q == DPIO_WR_IDLE && !wr_fire
                && !(w_held_q || s_axi_wvalid && s_axi_wready));
        end
    end

    // Read channel: one cycle from address to data
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `DPIO_RESP_OKAY;
        end else if (i_clk_en) begin
            s_axi_arready <= 1'b0;
            if (rd_fire && !s_axi_arready) begin
                s_axi_arready <= 1'b1;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_d.data;
                s_axi_rresp <= rd_d.resp;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // One latch per pin of ports A and B; software writable
    // Latches have no reset; writes land whatever the direction
    always_ff @(posedge i_clock) begin
        if (wr_en && wr_hit_a_l) begin
            a_latch_q <= w_data[7:0];
        end
        if (wr_en && wr_hit_b_l) begin
            b_latch_q <= w_data[5:0];
            b_loaded_q <= 1'b1;
        end
    end

    // Catch the reset-default option at reset release
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            rst_seen_q <= 1'b1;
        end else if (i_clk_en) begin
            rst_seen_q <= 1'b0;
        end
    end

    // Directions clear on reset; port B too
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            a_dir_q <= `DPIO_DIR_RESET;
            b_dir_q <= 6'h00;
            a_pdi_q <= `DPIO_PDI_RESET;
            b_pdi_q <= 6'h00;
        end else if (i_clk_en) begin
            if (rst_seen_q && i_pulldown_reset_default_option) begin
                // Option inhibits A pulldowns; and B
                a_pdi_q <= `DPIO_PDI_OPTION_SET;
                b_pdi_q <= 6'h3F;
            end else begin
                if (wr_en && wr_hit_a_p) begin
                    a_pdi_q <= w_data[7:0];
                end
                if (wr_en && wr_hit_b_p) begin
                    b_pdi_q <= w_data[5:0];
                end
            end
            if (wr_en && wr_hit_a_d) begin
                a_dir_q <= w_data[7:0];
            end
            if (wr_en && wr_hit_b_d) begin
                b_dir_q <= w_data[5:0];
            end
        end
    end

    // Drivers follow direction; pulldowns only matter on inputs
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_first_port_bits <= 8'h00;
            o_first_port_bits_oe <= 8'h00;
            o_first_port_pull_disable_bits <= 8'h00;
            o_second_port_bits <= 6'h00;
            o_second_port_bits_oe <= 6'h00;
            o_second_port_pull_disable_bits <= 6'h00;
            o_ext_irq_pins <= 4'h0;
        end else if (i_clk_en) begin
            o_first_port_bits <= a_latch_q;
            o_first_port_bits_oe <= a_dir_q;
            o_first_port_pull_disable_bits <= a_pdi_q | a_dir_q;
            o_second_port_bits <= b_latch_q;
            o_second_port_bits_oe <= b_dir_q;
            o_second_port_pull_disable_bits <= b_pdi_q | b_dir_q;
            // Pins 0-3 routed to interrupt logic
            o_ext_irq_pins <= i_port_interrupt_option
                ? a_pin_s[3:0] : 4'h0;
        end
    end

    // Software orders latch before direction; no hardware check

    property p_dir_reset;
        @(posedge i_clock) i_rst |=> (a_dir_q == 8'h00 && b_dir_q == 6'h00);
    endproperty
    a_dir_reset: assert property (p_dir_reset)
        else $error("direction not cleared by reset");

    property p_oe_follows_dir;
        @(posedge i_clock) disable iff (i_rst)
        i_clk_en |=> (o_first_port_bits_oe == $past(a_dir_q));
    endproperty
    a_oe_follows_dir: assert property (p_oe_follows_dir)
        else $error("port A enable does not follow direction");

    property p_rd_a;
        @(posedge i_clock) disable iff (i_rst)
        i_clk_en && s_axi_arvalid && s_axi_arready
        && s_axi_araddr == 10'h000
        |=> s_axi_rvalid && s_axi_rdata[7:0] == $past(a_view);
    endproperty
    a_rd_a: assert property (p_rd_a)
        else $error("port A read data wrong");

    property p_rd_b_top;
        @(posedge i_clock) disable iff (i_rst)
        i_clk_en && s_axi_arvalid && s_axi_arready
        && (s_axi_araddr == 10'h004 || s_axi_araddr == 10'h014)
        |=> s_axi_rdata[31:6] == 26'h000_0000;
    endproperty
    a_rd_b_top: assert property (p_rd_b_top)
        else $error("unimplemented read bits not zero");

    property p_latch_write;
        @(posedge i_clock) disable iff (i_rst)
        wr_en && wr_hit_a_l |=> a_latch_q == $past(w_data[7:0]);
    endproperty
    a_latch_write: assert property (p_latch_write)
        else $error("port A latch write lost");

    property p_latch_keep;
        @(posedge i_clock) i_rst && b_loaded_q && !(wr_en && wr_hit_b_l)
        |=> b_latch_q == $past(b_latch_q);
    endproperty
    a_latch_keep: assert property (p_latch_keep)
        else $error("port B latch changed by reset");

    property p_pdi_option;
        @(posedge i_clock) disable iff (i_rst)
        i_clk_en && rst_seen_q && i_pulldown_reset_default_option
        |=> a_pdi_q == 8'hFF && b_pdi_q == 6'h3F;
    endproperty
    a_pdi_option: assert property (p_pdi_option)
        else $error("option did not inhibit pulldowns");

    property p_irq_gate;
        @(posedge i_clock) disable iff (i_rst)
        i_clk_en && !i_port_interrupt_option |=> o_ext_irq_pins == 4'h0;
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("interrupt pins active without option");

    property p_pdi_read_zero;
        @(posedge i_clock) disable iff (i_rst)
        i_clk_en && s_axi_arvalid && s_axi_arready
        && s_axi_araddr == 10'h040 |=> s_axi_rdata == 32'h0000_0000;
    endproperty
    a_pdi_read_zero: assert property (p_pdi_read_zero)
        else $error("inhibit register read not zero");
endmodule

/* src/dpio_regs.svh */
// Register map, field layout and reset values of the parallel I/O ports.
// Assumes inclusion by the package and the port module, once each.
`ifndef DPIO_REGS_SVH
`define DPIO_REGS_SVH

// Printed offsets are not all multiples of four: indices, byte = 4 * index
`define DPIO_IDX_A_LATCH 8'h00
`define DPIO_IDX_B_LATCH 8'h01
`define DPIO_IDX_A_DIR 8'h04
`define DPIO_IDX_B_DIR 8'h05
`define DPIO_IDX_A_PDI 8'h10
`define DPIO_IDX_B_PDI 8'h11
`define DPIO_ADDR_W 8
`define DPIO_A_WIDTH 8
`define DPIO_B_WIDTH 6
`define DPIO_DIR_RESET 8'h00
`define DPIO_PDI_RESET 8'h00
`define DPIO_PDI_OPTION_SET 8'hFF
`define DPIO_IRQ_PINS 4
`define DPIO_RESP_OKAY 2'b00
`define DPIO_RESP_SLVERR 2'b10

`endif

/* src/dpio_pkg.sv */
// Types shared by the parallel I/O port block.
// Assumes the register header sits beside it.
`include "dpio_regs.svh"

package dpio_pkg;

    typedef struct packed {
        logic [7:0] drive;
        logic [7:0] enable;
        logic [7:0] pull_off;
    } dpio_pin_ctl_type;

    typedef struct packed {
        logic [31:0] data;
        logic [1:0] resp;
    } dpio_rresp_type;

    typedef enum logic [1:0] {
        DPIO_WR_IDLE = 2'b00,
        DPIO_WR_RESP = 2'b01
    } dpio_wr_state_type;

endpackage

/* src/dpio_sync.sv */
// Two-flop synchroniser for the asynchronous pin levels.
// Assumes one clock; the enable freezes both stages.
`timescale 1ns/1ns

module dpio_sync #(
    parameter int WIDTH = 8
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_enable,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_q;

    initial begin
        if (WIDTH < 1) begin
            $error("dpio_sync: WIDTH must be positive");
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            meta_q <= '0;
            o_sync <= '0;
        end else if (i_enable) begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end
endmodule

/* dv/dpio_pin_model.sv */
// External circuitry on one parallel port: drivers, pulldowns, float.
// Assumes the design's drive, enable and pull-off outputs feed it.
`timescale 1ns/1ns

module dpio_pin_model #(
    parameter int W = 8
) (
    input wire logic i_clock,
    input wire logic [W-1:0] i_drive,
    input wire logic [W-1:0] i_oe,
    input wire logic [W-1:0] i_pull_off,
    input wire logic [W-1:0] i_ext_en,
    input wire logic [W-1:0] i_ext_val,
    output logic [W-1:0] o_level
);
    logic [W-1:0] last_q = '0;

    always_ff @(posedge i_clock) begin
        last_q <= o_level;
    end

    // Floating pins toggle so no stale level reads back
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (i_oe[i])
                o_level[i] = i_drive[i];
            else if (i_ext_en[i])
                o_level[i] = i_ext_val[i];
            else
                o_level[i] = i_pull_off[i] ? ~last_q[i] : 1'b0;
        end
    end
endmodule

/* dv/testbench.sv */
// Self-checking bench for the parallel ports over AXI4-Lite.
// Assumes the design, package and pin model are compiled first.
`timescale 1ns/1ns
`include "dpio_regs.svh"

module testbench;
    import dpio_pkg::*;
    localparam logic [9:0] A_LAT = 10'(4 * `DPIO_IDX_A_LATCH);
    localparam logic [9:0] B_LAT = 10'(4 * `DPIO_IDX_B_LATCH);
    localparam logic [9:0] A_DIR = 10'(4 * `DPIO_IDX_A_DIR);
    localparam logic [9:0] B_DIR = 10'(4 * `DPIO_IDX_B_DIR);
    localparam logic [9:0] A_PDI = 10'(4 * `DPIO_IDX_A_PDI);
    localparam logic [9:0] B_PDI = 10'(4 * `DPIO_IDX_B_PDI);
    logic clk = 0, rst = 1, opt_pd = 0, opt_irq = 0, clk_en = 1;
    logic [7:0] a_en = 0, a_val = 0, a_lvl, a_drv, a_oe, a_pd;
    logic [5:0] b_en = 0, b_val = 0, b_lvl, b_drv, b_oe, b_pd;
    logic [3:0] irq, wstrb = 0;
    logic [9:0] awaddr = 0, araddr = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [31:0] wdata = 0, rdata, rv;
    logic [1:0] bresp, rresp, resp;
    int failures = 0, checked = 0;

    always #4 clk = ~clk;

    dpio_ports dpio_ports_inst (
        .i_clock(clk), .i_rst(rst), .i_clk_en(clk_en),
        .i_pulldown_reset_default_option(opt_pd),
        .i_port_interrupt_option(opt_irq),
        .i_first_port_bits(a_lvl), .i_second_port_bits(b_lvl),
        .o_first_port_bits(a_drv), .o_first_port_bits_oe(a_oe),
        .o_first_port_pull_disable_bits(a_pd),
        .o_second_port_bits(b_drv), .o_second_port_bits_oe(b_oe),
        .o_second_port_pull_disable_bits(b_pd), .o_ext_irq_pins(irq),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
    );

    dpio_pin_model #(.W(8)) pins_a (.i_clock(clk), .i_drive(a_drv),
        .i_oe(a_oe), .i_pull_off(a_pd), .i_ext_en(a_en),
        .i_ext_val(a_val), .o_level(a_lvl));
    dpio_pin_model #(.W(6)) pins_b (.i_clock(clk), .i_drive(b_drv),
        .i_oe(b_oe), .i_pull_off(b_pd), .i_ext_en(b_en),
        .i_ext_val(b_val), .o_level(b_lvl));

    task automatic test_done;
        $display("checks %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        resp = bresp;
        bready <= 1'b0;
        if (n == 40) begin
            failures++;
            test_done();
        end
    endtask

    task automatic rd(input logic [9:0] a);
        int n;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rv = rdata;
        resp = rresp;
        rready <= 1'b0;
        if (n == 40) begin
            failures++;
            test_done();
        end
    endtask

    task automatic pulse_reset;
        @(posedge clk);
        rst <= 1'b1;
        cyc(2);
        rst <= 1'b0;
        cyc(3);
    endtask

    initial begin
        cyc(6);
        rst <= 1'b0;
        rd(A_DIR); chk(rv, 32'h0000_0000);
        rd(B_DIR); chk(rv, 32'h0000_0000);
        rd(A_PDI); chk(rv, 32'h0000_0000);
        chk(resp, `DPIO_RESP_OKAY);
        rd(B_PDI); chk(rv, 32'h0000_0000);
        chk({a_oe, b_oe}, 32'h0000_0000);
        a_en <= 8'hff;
        a_val <= 8'h3c;
        b_en <= 6'h3f;
        b_val <= 6'h15;
        wr(A_LAT, 32'h0000_00a5);
        wr(B_LAT, 32'h0000_00ff);
        cyc(3);
        rd(A_LAT); chk(rv, 32'h0000_003c);
        rd(B_LAT); chk(rv, 32'h0000_0015);
        wr(B_PDI, 32'h0000_002a);
        cyc(2);
        chk(b_pd, 32'h0000_002a);
        // Latch loaded above, before any direction bit goes high
        a_en <= 8'h0f;
        b_en <= 6'h00;
        wr(A_DIR, 32'h0000_00f0);
        wr(B_DIR, 32'h0000_00ff);
        cyc(2);
        rd(A_DIR); chk(rv, 32'h0000_00f0);
        rd(A_LAT); chk(rv, 32'h0000_00ac);
        chk(a_oe, 32'h0000_00f0);
        chk(a_drv, 32'h0000_00a5);
        rd(B_DIR); chk(rv, 32'h0000_003f);
        rd(B_LAT); chk(rv, 32'h0000_003f);
        chk(b_oe, 32'h0000_003f);
        a_en <= 8'h00;
        cyc(4);
        rd(A_LAT); chk(rv, 32'h0000_00a0);
        wr(A_PDI, 32'h0000_005a);
        cyc(2);
        chk(a_pd, 32'h0000_00fa);
        rd(A_PDI); chk(rv, 32'h0000_0000);
        wr(10'h008, 32'h0000_00ff); chk(resp, `DPIO_RESP_SLVERR);
        rd(10'h002); chk(resp, `DPIO_RESP_SLVERR);
        pulse_reset();
        chk({a_oe, b_oe}, 32'h0000_0000);
        chk(a_pd, 32'h0000_0000);
        wr(A_DIR, 32'h0000_00ff);
        wr(B_DIR, 32'h0000_003f);
        rd(A_LAT); chk(rv, 32'h0000_00a5);
        rd(B_LAT); chk(rv, 32'h0000_003f);
        wr(A_DIR, 32'h0000_0000);
        wr(B_DIR, 32'h0000_0000);
        opt_pd <= 1'b1;
        pulse_reset();
        chk(a_pd, 32'h0000_00ff);
        chk(b_pd, 32'h0000_003f);
        opt_pd <= 1'b0;
        a_en <= 8'hff;
        a_val <= 8'h5a;
        opt_irq <= 1'b1;
        cyc(5);
        chk(irq, 32'h0000_000a);
        clk_en <= 1'b0;
        a_val <= 8'h05;
        cyc(5);
        chk(irq, 32'h0000_000a);
        clk_en <= 1'b1;
        cyc(5);
        chk(irq, 32'h0000_0005);
        opt_irq <= 1'b0;
        cyc(3);
        chk(irq, 32'h0000_0000);
        test_done();
    end
endmodule
